// ---- src/setw_host.sv ----
`timescale 1ns/10ps
module setw_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 8
) (
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int unsigned PW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW:0]         wp;
      logic [PW:0]         rp;
   } setw_fifo_s;

   setw_fifo_s q;
   setw_fifo_s n;

   // full when pointers differ only in the wrap bit
   assign in_ready = (q.wp ^ q.rp) != {1'b1, {PW{1'b0}}};
   assign out_valid = q.wp != q.rp;
   assign out_data = q.mem[q.rp[PW-1:0]];

   // pointer and storage update
   always_comb begin
      n = q;
      if (in_valid && in_ready) begin
         n.mem[q.wp[PW-1:0]] = in_data;
         n.wp = q.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         n.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule

module setw_host
   import setw_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       arst_n,
   setw_if.host            bus,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic [1:0] cmd_op,
   input  wire logic [2:0] cmd_cs,
   input  wire logic [7:0] cmd_addr,
   input  wire logic [3:0] cmd_len,
   input  wire logic       wr_valid,
   output logic            wr_ready,
   input  wire logic [7:0] wr_data,
   output logic            rd_valid,
   output logic [7:0]      rd_data,
   output logic            done,
   output logic            done_err
);

   typedef struct packed {
      logic                  s1;
      logic                  s2;
      setw_mst_e             st;
      setw_ph_e              ph;
      logic [1:0]            qc;
      logic [SETW_DIV_W-1:0] div;
      logic [3:0]            bit_i;
      logic [7:0]            tx;
      logic [7:0]            rx;
      logic [1:0]            op;
      logic [2:0]            cs;
      logic [7:0]            addr;
      logic [3:0]            len;
      logic [3:0]            cnt;
      logic [7:0]            tries;
      logic                  scl;
      logic                  oe;
      logic                  acked;
      logic                  retry;
      logic                  err;
      logic                  done;
      logic                  rd_valid;
      logic [7:0]            rd_data;
   } setw_host_s;

   setw_host_s q;
   setw_host_s n;
   logic       tick;
   logic       f_valid;
   logic       pop;
   logic [7:0] f_data;
   logic       need;
   logic       tx_bit;
   logic       more;

   // write data buffer; its ready is the user's back-pressure
   setw_fifo #(.W(SETW_FIFO_W), .D(SETW_FIFO_D)) u_fifo (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_data)
   );

   // serial clock divider and bit cell sequencer
   always_comb begin
      n = q;
      n.s1 = bus.sda;
      n.s2 = q.s1;
      n.done = 1'b0;
      n.rd_valid = 1'b0;
      tick = (q.div == SETW_DIV_W'(SETW_QTR_CYC - 1));
      n.div = tick ? '0 : q.div + 1'b1;
      need = (q.ph == P_DATA) && (q.bit_i == 4'h0);
      pop = 1'b0;
      tx_bit = need ? f_data[7] : q.tx[7];
      more = (q.cnt + 4'h1) != q.len;
      unique case (q.st)
         M_IDLE: begin
            n.scl = 1'b1;
            n.oe = 1'b0;
            if (cmd_valid) begin
               n.op = cmd_op;
               n.cs = cmd_cs;
               n.addr = cmd_addr;
               n.len = cmd_len;
               n.tries = 8'h00;
               n.err = 1'b0;
               n.retry = 1'b0;
               n.qc = 2'h0;
               n.div = '0;
               n.ph = (cmd_op == OP_CUR) ? P_RSEL : P_SEL;
               n.st = M_START;
            end
         end
         M_START: begin
            if (tick) begin
               n.qc = q.qc + 1'b1;
               unique case (q.qc)
                  2'h0: n.oe = 1'b0;
                  2'h1: n.scl = 1'b1;
                  2'h2: n.oe = 1'b1;
                  2'h3: begin
                     n.scl = 1'b0;
                     n.tx = {SETW_DEV_TYPE, q.cs, q.ph == P_RSEL}; // RULE3 RULE18
                     n.bit_i = 4'h0;
                     n.st = M_BIT;
                  end
               endcase
            end
         end
         M_BIT: begin
            if (tick && !(q.qc == 2'h0 && need && !f_valid)) begin
               n.qc = q.qc + 1'b1;
               unique case (q.qc)
                  2'h0: begin
                     if (q.bit_i == SETW_ACK_BIT) begin
                        n.oe = (q.ph == P_RDATA) && more; // RULE17 RULE19
                     end else begin
                        n.oe = (q.ph != P_RDATA) && !tx_bit;
                        if (need) begin
                           pop = 1'b1;
                           n.tx = f_data;
                        end
                     end
                  end
                  2'h1: n.scl = 1'b1;
                  2'h2: begin
                     if (q.bit_i == SETW_ACK_BIT) begin
                        n.acked = ~q.s2;
                     end else begin
                        n.rx = {q.rx[6:0], q.s2};
                     end
                  end
                  2'h3: begin
                     n.scl = 1'b0;
                     n.bit_i = q.bit_i + 1'b1;
                     n.tx = {q.tx[6:0], 1'b0};
                     if (q.bit_i == SETW_ACK_BIT) begin
                        n.bit_i = 4'h0;
                        unique case (q.ph)
                           P_SEL: begin
                              n.tx = q.addr; // RULE5
                              n.ph = P_ADDR;
                              if (!q.acked) begin
                                 n.retry = 1'b1; // RULE14
                                 n.st = M_STOP;
                              end
                           end
                           P_ADDR: begin
                              n.cnt = 4'h0;
                              if (!q.acked) begin
                                 n.err = 1'b1;
                                 n.st = M_STOP;
                              end else if (q.op == OP_WRITE) begin
                                 n.ph = P_DATA;
                              end else begin
                                 n.ph = P_RSEL; // RULE18
                                 n.st = M_START;
                              end
                           end
                           P_DATA: begin
                              n.cnt = q.cnt + 1'b1;
                              if (!q.acked) begin
                                 n.err = 1'b1;
                                 n.st = M_STOP;
                              end else if (!more) begin
                                 n.st = M_STOP; // RULE7 RULE13
                              end
                           end
                           P_RSEL: begin
                              n.cnt = 4'h0;
                              n.ph = P_RDATA;
                              if (!q.acked) begin
                                 n.retry = 1'b1; // RULE14
                                 n.st = M_STOP;
                              end
                           end
                           P_RDATA: begin
                              n.rd_valid = 1'b1;
                              n.rd_data = q.rx;
                              n.cnt = q.cnt + 1'b1;
                              if (!more) begin
                                 n.st = M_STOP; // RULE17 RULE19
                              end
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
         M_STOP: begin
            if (tick) begin
               n.qc = q.qc + 1'b1;
               unique case (q.qc)
                  2'h0: n.oe = 1'b1;
                  2'h1: n.scl = 1'b1;
                  2'h2: n.oe = 1'b0;
                  2'h3: begin
                     n.retry = 1'b0;
                     if (q.retry && q.tries != SETW_POLL_MAX) begin
                        n.tries = q.tries + 1'b1; // RULE14
                        n.ph = (q.op == OP_CUR) ? P_RSEL : P_SEL;
                        n.st = M_START;
                     end else begin
                        n.done = 1'b1;
                        n.err = q.err | q.retry;
                        n.st = M_IDLE;
                     end
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.s1 <= 1'b1;
         q.s2 <= 1'b1;
         q.scl <= 1'b1;
         q.st <= M_IDLE;
         q.ph <= P_SEL;
      end else begin
         q <= n;
      end
   end

   assign cmd_ready = (q.st == M_IDLE);
   assign bus.scl = q.scl;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe = q.oe;
   assign rd_valid = q.rd_valid;
   assign rd_data = q.rd_data;
   assign done = q.done;
   assign done_err = q.err;

endmodule

// ---- src/setw_pkg.sv ----
package setw_pkg;
   // system clock and serial clock rates
   localparam int unsigned SETW_CLK_HZ   = 40_000_000;
   localparam int unsigned SETW_SCL_KHZ  = 100;
   // master quarter bit cell, in system clocks
   localparam int unsigned SETW_QTR_CYC  = SETW_CLK_HZ / (SETW_SCL_KHZ * 1000 * 4);
   localparam int unsigned SETW_DIV_W    = 7;
   // program cycle times, longest, rounded down
   localparam int unsigned SETW_TW_MS    = 10;
   localparam int unsigned SETW_TW2_MS   = 20;
   localparam int unsigned SETW_TW_CYC   = SETW_TW_MS * (SETW_CLK_HZ / 1000);
   localparam int unsigned SETW_TW2_CYC  = SETW_TW2_MS * (SETW_CLK_HZ / 1000);
   localparam int unsigned SETW_TMR_W    = 20;
   // device type code; value is arbitrary
   localparam logic [3:0]  SETW_DEV_TYPE = 4'h5;
   // array geometry and contents on delivery
   localparam int unsigned SETW_MEM_N    = 256;
   localparam int unsigned SETW_LATCH_N  = 8;
   localparam logic [7:0]  SETW_ERASED   = 8'hFF;
   // byte engine
   localparam logic [3:0]  SETW_ACK_BIT  = 4'h8;
   localparam logic [3:0]  SETW_LAST_BIT = 4'h7;
   // host side
   localparam int unsigned SETW_FIFO_W   = 8;
   localparam int unsigned SETW_FIFO_D   = 8;
   localparam logic [7:0]  SETW_POLL_MAX = 8'hFF;

   typedef enum logic [5:0] {
      D_IDLE = 6'h01,
      D_RX   = 6'h02,
      D_ACK  = 6'h04,
      D_TX   = 6'h08,
      D_MACK = 6'h10,
      D_BUSY = 6'h20
   } setw_dst_e;

   typedef enum logic [2:0] {
      K_SEL  = 3'h1,
      K_ADDR = 3'h2,
      K_DATA = 3'h4
   } setw_kind_e;

   typedef enum logic [3:0] {
      M_IDLE  = 4'h1,
      M_START = 4'h2,
      M_BIT   = 4'h4,
      M_STOP  = 4'h8
   } setw_mst_e;

   typedef enum logic [4:0] {
      P_SEL   = 5'h01,
      P_ADDR  = 5'h02,
      P_DATA  = 5'h04,
      P_RSEL  = 5'h08,
      P_RDATA = 5'h10
   } setw_ph_e;

   typedef enum logic [1:0] {
      OP_WRITE = 2'h0,
      OP_RAND  = 2'h1,
      OP_CUR   = 2'h2
   } setw_op_e;
endpackage

// ---- src/setw_if.sv ----
`timescale 1ns/10ps
interface setw_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic sda;

   // wired-and data line with pull-up
   assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

   modport host (output scl, output m_sda_o, output m_sda_oe, input sda);
   modport dev  (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

// ---- src/setw_dev.sv ----
`timescale 1ns/10ps
//Contract
//RULE1: upper nibble must equal device type code
//RULE2: three select bits match chip select inputs
//RULE3: eighth select bit: one read, zero write
//RULE4: matched select byte acknowledged on ninth bit
//RULE5: write select followed by acked byte address
//RULE6: write protect high leaves array unchanged
//RULE7: byte write acked in any mode
//RULE8: mode high: multibyte write, each acked
//RULE9: program time ten, or twenty spanning rows
//RULE10: master writes at most four multibyte bytes
//RULE11: mode low: page write, eight bytes, acked
//RULE12: page write increments low three bits only
//RULE13: stop starts program; device then deaf
//RULE14: no select ack while programming; polling
//RULE15: reads ignore mode; array starts all FFh
//RULE16: read select: ack, send byte, increment
//RULE17: single read ends with nack and stop
//RULE18: random read: dummy write, repeated start
//RULE19: acked read byte brings next address
//RULE20: address counter wraps to zero reading
//RULE21: no master ack ends read, standby
//RULE22: unmatched select ignored until next start
module setw_dev
   import setw_pkg::*;
#(
   parameter int unsigned TW_CYCLES  = SETW_TW_CYC,
   parameter int unsigned TW2_CYCLES = SETW_TW2_CYC
) (
   input  wire logic       mclk,
   input  wire logic       arst_n,
   setw_if.dev             bus,
   input  wire logic [2:0] chip_select_inputs,
   input  wire logic       write_protect_input,
   input  wire logic       mode_pin,
   output logic            prog_busy
);

   typedef struct packed {
      logic [6:0]      s1;
      logic [6:0]      s2;
      logic            scl_p;
      logic            sda_p;
      setw_dst_e       st;
      setw_kind_e      kind;
      logic [3:0]      bits;
      logic [7:0]      sh;
      logic [7:0]      addr;
      logic            rw;
      logic            oe;
      logic            span;
      logic [7:0]      first;
      logic [3:0]      cnt;
      logic [7:0]      lv;
      logic [7:0][7:0] la;
      logic [7:0][7:0] ld;
      logic [SETW_TMR_W-1:0] tmr;
   } setw_dev_s;

   setw_dev_s  q;
   setw_dev_s  n;
   logic [7:0] mem [SETW_MEM_N];
   logic       scl;
   logic       sda;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;
   logic [2:0] idx;
   logic [7:0] rd_byte;

   assign rd_byte = mem[q.addr];

   // next state of the slave protocol engine
   always_comb begin
      n = q;
      idx = 3'h0;
      n.s1 = {chip_select_inputs, write_protect_input, mode_pin, bus.sda, bus.scl};
      n.s2 = q.s1;
      n.scl_p = q.s2[0];
      n.sda_p = q.s2[1];
      scl = q.s2[0];
      sda = q.s2[1];
      rise = scl & ~q.scl_p;
      fall = ~scl & q.scl_p;
      start = scl & q.scl_p & q.sda_p & ~sda;
      stop = scl & q.scl_p & ~q.sda_p & sda;
      if (q.st == D_BUSY) begin
         // deaf to the bus until the program cycle ends
         n.oe = 1'b0; // RULE13 RULE14
         if (q.tmr == '0) begin
            n.st = D_IDLE;
            n.lv = 8'h00;
         end else begin
            n.tmr = q.tmr - 1'b1;
         end
      end else if (start) begin
         n.st = D_RX;
         n.kind = K_SEL;
         n.bits = 4'h0;
         n.oe = 1'b0;
         n.lv = 8'h00;
         n.span = 1'b0;
      end else if (stop) begin
         n.oe = 1'b0;
         if (q.lv != 8'h00) begin
            n.st = D_BUSY; // RULE13
            n.tmr = q.span ? SETW_TMR_W'(TW2_CYCLES - 1) : SETW_TMR_W'(TW_CYCLES - 1); // RULE9
         end else begin
            n.st = D_IDLE;
         end
      end else begin
         unique case (q.st)
            D_IDLE: begin
               n.oe = 1'b0; // RULE22
            end
            D_RX: begin
               if (rise) begin
                  n.sh = {q.sh[6:0], sda};
                  n.bits = q.bits + 1'b1;
               end else if (fall && q.bits == SETW_ACK_BIT) begin
                  unique case (q.kind)
                     K_SEL: begin
                        if (q.sh[7:4] == SETW_DEV_TYPE && q.sh[3:1] == q.s2[6:4]) begin // RULE1 RULE2
                           n.oe = 1'b1; // RULE4
                           n.st = D_ACK;
                           n.rw = q.sh[0]; // RULE3 RULE18
                           n.cnt = 4'h0;
                        end else begin
                           n.st = D_IDLE; // RULE22
                        end
                     end
                     K_ADDR: begin
                        n.addr = q.sh; // RULE5
                        n.oe = 1'b1;
                        n.st = D_ACK;
                     end
                     K_DATA: begin
                        n.oe = 1'b1; // RULE7 RULE8 RULE11
                        n.st = D_ACK;
                        idx = q.s2[2] ? q.cnt[2:0] : q.addr[2:0];
                        if (!q.s2[3]) begin // RULE6
                           n.la[idx] = q.addr;
                           n.ld[idx] = q.sh;
                           n.lv[idx] = 1'b1;
                           if (q.lv == 8'h00) begin
                              n.first = q.addr;
                           end else if (q.s2[2] && q.addr[7:2] != q.first[7:2]) begin
                              n.span = 1'b1; // RULE9
                           end
                        end
                        n.cnt = q.cnt + 1'b1;
                        // multibyte walks the whole counter, page wraps in the row
                        n.addr = q.s2[2] ? q.addr + 1'b1 : {q.addr[7:3], q.addr[2:0] + 3'h1}; // RULE12
                     end
                  endcase
               end
            end
            D_ACK: begin
               if (fall) begin
                  n.oe = 1'b0;
                  n.bits = 4'h0;
                  if (q.kind == K_SEL && q.rw) begin
                     n.sh = rd_byte; // RULE15 RULE16
                     n.oe = ~rd_byte[7];
                     n.addr = q.addr + 1'b1; // RULE20
                     n.st = D_TX;
                  end else begin
                     n.st = D_RX;
                     n.kind = (q.kind == K_SEL) ? K_ADDR : K_DATA;
                  end
               end
            end
            D_TX: begin
               if (fall) begin
                  if (q.bits == SETW_LAST_BIT) begin
                     n.oe = 1'b0;
                     n.st = D_MACK;
                  end else begin
                     n.sh = {q.sh[6:0], 1'b0};
                     n.oe = ~q.sh[6];
                     n.bits = q.bits + 1'b1;
                  end
               end
            end
            D_MACK: begin
               if (rise && sda) begin
                  n.st = D_IDLE; // RULE21 RULE17
               end else if (fall) begin
                  n.sh = rd_byte; // RULE19
                  n.oe = ~rd_byte[7];
                  n.addr = q.addr + 1'b1; // RULE20
                  n.bits = 4'h0;
                  n.st = D_TX;
               end
            end
            D_BUSY: begin
               n.oe = 1'b0;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.s1 <= 7'h03;
         q.s2 <= 7'h03;
         q.scl_p <= 1'b1;
         q.sda_p <= 1'b1;
         q.st <= D_IDLE;
         q.kind <= K_SEL;
      end else begin
         q <= n;
      end
   end

   // array, erased at reset, written from the latches at end of program
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < SETW_MEM_N; i++) begin
            mem[i] <= SETW_ERASED; // RULE15
         end
      end else if (q.st == D_BUSY && q.tmr == '0) begin
         for (int i = 0; i < SETW_LATCH_N; i++) begin
            if (q.lv[i]) begin
               mem[q.la[i]] <= q.ld[i];
            end
         end
      end
   end

   // open-drain output only ever pulls low
   assign bus.d_sda_o = 1'b0;
   assign bus.d_sda_oe = q.oe;
   assign prog_busy = (q.st == D_BUSY);

endmodule

// ---- dv/setw_chk_sva.sv ----
`timescale 1ns/10ps
module setw_chk #(
   parameter int unsigned TW_CYCLES  = 200,
   parameter int unsigned TW2_CYCLES = 400
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic scl,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic sda,
   input wire logic prog_busy
);
   logic [19:0] busy_cnt_q;

   // length of the running program cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt_q <= 20'h00000;
      end else if (prog_busy) begin
         busy_cnt_q <= busy_cnt_q + 20'h00001;
      end else begin
         busy_cnt_q <= 20'h00000;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   // device stays off the bus while programming
   chk_busy_deaf: assert property (prog_busy |-> !d_sda_oe)
      else $error("device drives data while programming");
   chk_busy_after_stop: assert property ($rose(prog_busy) |-> scl && sda)
      else $error("program cycle began without stop");
   chk_busy_hold: assert property ($rose(prog_busy) |=> prog_busy [*8])
      else $error("program cycle too short");
   chk_busy_len: assert property ($fell(prog_busy) |-> busy_cnt_q >= TW_CYCLES && busy_cnt_q <= TW2_CYCLES + 2)
      else $error("program cycle length out of range");
   // data changes only while the clock is low
   chk_oe_scl_low: assert property ($changed(d_sda_oe) |-> !scl)
      else $error("device data moved with clock high");
   chk_ack_holds: assert property (d_sda_oe && scl |=> d_sda_oe || !scl)
      else $error("device released data during clock high");
   // start and stop move data with clock high; the device must be off the line then
   chk_pull_only: assert property ($changed(sda) && scl |-> !d_sda_oe && !d_sda_o)
      else $error("device drives data across start or stop");
   chk_start_hold: assert property ($fell(sda) && scl |=> scl [*8])
      else $error("clock fell too soon after start");
endmodule

// ---- dv/test_serial_eeprom_two_wire_slave.sv ----
`timescale 1ns/10ps
module test_serial_eeprom_two_wire_slave;
   import setw_pkg::*;
   localparam int unsigned TW  = 200;
   localparam int unsigned TW2 = 400;
   localparam logic [2:0]  CS  = 3'h5;
   logic       mclk;
   logic       arst_n;
   logic       mode_pin;
   logic       wp;
   logic       prog_busy;
   logic       cmd_valid;
   logic       cmd_ready;
   logic [1:0] cmd_op;
   logic [7:0] cmd_addr;
   logic [3:0] cmd_len;
   logic       wr_valid;
   logic       wr_ready;
   logic [7:0] wr_data;
   logic       rd_valid;
   logic [7:0] rd_data;
   logic       done;
   logic       done_err;
   logic [7:0] rd_q[$];
   logic [2:0] cs_m;
   int         oe_cnt;
   int         bad_count;
   int         checked;
   int         i;

   setw_if bus_if ();
   setw_dev #(.TW_CYCLES(TW), .TW2_CYCLES(TW2)) setw_dev_inst (.mclk(mclk), .arst_n(arst_n), .bus(bus_if),
      .chip_select_inputs(CS), .write_protect_input(wp), .mode_pin(mode_pin), .prog_busy(prog_busy));
   setw_host setw_host_inst (.mclk(mclk), .arst_n(arst_n), .bus(bus_if), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_cs(cs_m), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
      .done(done), .done_err(done_err));
   setw_chk #(.TW_CYCLES(TW), .TW2_CYCLES(TW2)) setw_chk_inst (.mclk(mclk), .arst_n(arst_n),
      .scl(bus_if.scl), .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe), .d_sda_o(bus_if.d_sda_o),
      .d_sda_oe(bus_if.d_sda_oe), .sda(bus_if.sda), .prog_busy(prog_busy));

   // clock
   always #12.5 mclk = ~mclk;

   // collect read bytes mid-cycle, count cycles with the device pulling data
   always @(negedge mclk) begin
      if (rd_valid === 1'b1) begin
         rd_q.push_back(rd_data);
      end
      if (bus_if.d_sda_oe === 1'b1) begin
         oe_cnt++;
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one word into the fifo, valid left high
   task automatic push(input logic [7:0] d);
      wr_valid = 1'b1;
      wr_data = d;
      while (wr_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
   endtask

   // one command, then wait for completion
   task automatic run(input logic [1:0] op, input logic [7:0] addr, input logic [3:0] len);
      int n;
      rd_q.delete();
      cmd_op = op;
      cmd_addr = addr;
      cmd_len = len;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40000) begin
         @(negedge mclk);
         n++;
      end
      check({7'h00, done}, 8'h01);
      check({7'h00, done_err}, 8'h00);
   endtask

   task automatic final_report();
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      #2500000;
      bad_count++;
      final_report();
   end

   initial begin
      mclk = 1'b0;
      arst_n = 1'b0;
      mode_pin = 1'b0;
      wp = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_addr = 8'h00;
      cmd_len = 4'h0;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      cs_m = CS;
      bad_count = 0;
      checked = 0;
      repeat (3) @(negedge mclk);
      arst_n = 1'b1;
      // foreign chip select is never acked; a reset lands in the stop of the first try, before any retry starts
      cs_m = 3'h2;
      cmd_op = OP_CUR;
      cmd_len = 4'h1;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      i = oe_cnt;
      repeat (4200) @(negedge mclk);
      check({7'h00, oe_cnt != i}, 8'h00);
      arst_n = 1'b0;
      @(negedge mclk);
      arst_n = 1'b1;
      cs_m = CS;
      @(negedge mclk);
      check({2'h0, cmd_ready, bus_if.scl, done, prog_busy, bus_if.m_sda_oe, bus_if.d_sda_oe}, 8'h30);
      // fill the fifo until it refuses
      for (i = 0; i < 8; i++) begin
         push(8'hA0 | i[7:0]);
      end
      wr_valid = 1'b0;
      check({7'h00, wr_ready}, 8'h00);
      // page write of eight bytes from FE wraps inside the row
      run(OP_WRITE, 8'hFE, 4'h8);
      check({7'h00, wr_ready}, 8'h01);
      // random read across the top: FF then 00 still erased
      run(OP_RAND, 8'hFF, 4'h2);
      check(rd_q[0], 8'hA1);
      check(rd_q[1], SETW_ERASED);
      check(8'(rd_q.size()), 8'h02);
      // protected multibyte write leaves the byte alone
      wp = 1'b1;
      mode_pin = 1'b1;
      push(8'h55);
      wr_valid = 1'b0;
      run(OP_WRITE, 8'hFF, 4'h1);
      wp = 1'b0;
      run(OP_RAND, 8'hFF, 4'h1);
      check(rd_q[0], 8'hA1);
      final_report();
   end
endmodule
